// ===== ccs_supervisor.sv
// Charge cycle supervisor: phases, timers, temperature, faults, interrupt
//
// Operation
// - Phase field reads 00 off, 01 precharge, 10 fast charge, 11 done.
// - Current, voltage or thermal limiting blocks termination, halves timer.
// - Terminate above recharge level, below term current; battery switch off once top-off ends.
// - Termination sets phase 11 and pulses the interrupt.
// - Termination enable low prevents termination.
// - Top-off timer follows safety timer hold and half rate.
// - Running flag high while top-off timer runs.
// - Top-off timer reset on enable rise, termination rise, register reset.
// - Top-off length captured at termination, later writes wait.
// - Interrupt on top-off start and on top-off expiry.
// - Start only inside thermistor window; outside it charging pauses.
// - Warm band uses programmed voltage or fixed 4.1 V by select bit.
// - Cool band optionally cuts current to 20 percent.
// - Boost thermistor out of range suspends boost, source 000, fault.
// - Safety time two hours when battery low, else five or ten hours by duration field.
// - Safety expiry sets fault 11 and interrupts.
// - Safety duration programmable, timer can be disabled.
// - Half-rate counting in limiting or cool band, enable bit gates it.
// - Timer held during faults, reset on charge restart.
// - Input overvoltage stops switching, fault 01, interrupt, auto resume.
// - System overvoltage at minimum stops switching, enables discharge load.
// - Boost short retries seven times, then disables boost with fault.
// - Boost overvoltage stops boost, clears enable, fault, interrupt.
`timescale 1ns/1ns
`default_nettype none
module ccs_supervisor #(
   parameter int TICK_CYC = ccs_pkg::TICK_CYC
) (
   input  wire logic                clk_in,
   input  wire logic                srst_in,
   input  wire ccs_pkg::ccs_pins_s  pins_in,
   input  wire ccs_pkg::ccs_cfg_s   cfg_in,
   input  wire logic                reg_defaults_in,
   input  wire logic                boost_wr_in,
   input  wire logic                boost_wdata_in,
   output var  logic [1:0]          charge_phase_field_out,
   output var  logic [1:0]          charge_fault_field_out,
   output var  logic                topoff_running_flag_out,
   output var  logic                thermistor_fault_flag_out,
   output var  logic                boost_fault_flag_out,
   output var  logic                boost_enable_out,
   output var  logic                boost_active_out,
   output var  logic [2:0]          input_source_field_out,
   output var  logic [2:0]          ov_threshold_sel_out,
   output var  logic                charge_active_out,
   output var  logic                battery_switch_on_out,
   output var  logic                switching_en_out,
   output var  logic                sys_discharge_out,
   output var  logic                vreg_fixed_4v1_out,
   output var  logic                ichg_cut_20pct_out,
   output var  logic                int_n_out
);

   typedef struct packed {
      ccs_pkg::ccs_pins_s  sync1;
      ccs_pkg::ccs_pins_s  sync2;
      ccs_pkg::ccs_state_e st;
      logic [15:0]         safe_cnt;
      logic                safe_fault;
      logic [11:0]         top_cnt;
      logic [11:0]         top_lim;
      logic                topoff_on;
      logic                en_q;
      logic                inov_q;
      logic [11:0]         int_cnt;
      logic                int_n;
      logic                boost_en;
      logic                boost_fault;
      logic [2:0]          retry_cnt;
      logic [11:0]         retry_wait;
      logic                boost_run;
      logic                therm_fault;
      logic [2:0]          src_field;
      logic [2:0]          ov_sel;
      logic [1:0]          phase;
      logic [1:0]          fault_field;
      logic                chg_act;
      logic                batt_sw;
      logic                sw_en;
      logic                sys_dis;
      logic                vreg_4v1;
      logic                cut_20;
   } ccs_top_s;

   ccs_top_s s;
   ccs_top_s next_s;
   ccs_pkg::ccs_pins_s p;

   logic tick;
   logic enabled;
   logic en_rise;
   logic limiting;
   logic charging;
   logic hold;
   logic slow;
   logic term_ev;
   logic top_start_ev;
   logic top_exp_ev;
   logic safe_exp_ev;
   logic inov_ev;
   logic boost_fail_ev;
   logic boost_ov_ev;
   logic any_ev;
   logic [15:0] safe_lim;

   function automatic ccs_pkg::ccs_state_e entry_state(input logic low_v);
      entry_state = low_v ? ccs_pkg::ST_PRE : ccs_pkg::ST_FAST;
   endfunction

   function automatic logic [1:0] phase_of(input ccs_pkg::ccs_state_e st);
      case (st)
         ccs_pkg::ST_PRE:  phase_of = ccs_pkg::PH_PRE;
         ccs_pkg::ST_FAST: phase_of = ccs_pkg::PH_FAST;
         ccs_pkg::ST_DONE: phase_of = ccs_pkg::PH_DONE;
         default:          phase_of = ccs_pkg::PH_DIS;
      endcase
   endfunction

   assign p        = s.sync2;
   assign enabled  = cfg_in.charge_enable_bit & ~p.charge_enable_pin_n;
   assign en_rise  = enabled & ~s.en_q;
   assign limiting = p.input_current_limit_flag | p.input_voltage_limit
                     | p.thermal_reg;
   assign charging = (s.st == ccs_pkg::ST_PRE) | (s.st == ccs_pkg::ST_FAST);
   assign hold     = p.input_overvoltage_event | ~p.thermistor_sense_ok;
   // Halving only while the enable bit allows it
   assign slow     = cfg_in.slow_count_enable
                     & (limiting | p.thermistor_sense_cool);

   // Low battery forces the two-hour limit, else the programmed one
   assign safe_lim = p.batt_low ? ccs_pkg::SAFE_LOW_TICKS
                   : (cfg_in.safety_duration_field ? ccs_pkg::SAFE_LONG_TICKS
                                                   : ccs_pkg::SAFE_SHORT_TICKS);

   // Termination needs no limiting and the enable bit
   assign term_ev = (s.st == ccs_pkg::ST_FAST) & ~hold & enabled
                    & p.batt_above_rechg & p.cur_below_term
                    & cfg_in.term_enable & ~limiting;
   assign top_start_ev = term_ev & (cfg_in.topoff_sel != 2'h0);
   assign top_exp_ev   = s.topoff_on & tick & ~en_rise & ~reg_defaults_in
                         & (s.top_cnt + 12'h001 >= s.top_lim);
   assign safe_exp_ev  = charging & enabled & tick & ~en_rise
                         & cfg_in.safety_timer_enable
                         & (s.safe_cnt + 16'h0001 >= safe_lim);
   assign inov_ev       = p.input_overvoltage_event & ~s.inov_q;
   assign boost_ov_ev   = s.boost_en & p.boost_overvoltage;
   assign boost_fail_ev = s.boost_run & p.boost_short & ~boost_ov_ev
                          & (s.retry_cnt == ccs_pkg::BOOST_RETRIES);
   assign any_ev = term_ev | top_start_ev | top_exp_ev | safe_exp_ev
                   | inov_ev | boost_fail_ev | boost_ov_ev;

   // Same tick paces both timers so top-off inherits hold and slowdown
   ccs_tick_gen #(
      .TICK_CYC (TICK_CYC)
   ) u_tick (
      .clk_in   (clk_in),
      .srst_in  (srst_in),
      .run_in   ((charging | s.topoff_on) & ~hold),
      .slow_in  (slow),
      .tick_out (tick)
   );

   always_comb begin
      next_s       = s;
      next_s.sync1 = pins_in;
      next_s.sync2 = s.sync1;
      next_s.en_q  = enabled;
      next_s.inov_q = p.input_overvoltage_event;

      // Charge sequencing
      case (s.st)
         ccs_pkg::ST_IDLE: begin
            // Start only inside the temperature window
            if (enabled & p.thermistor_sense_ok & ~s.safe_fault
                & ~p.input_overvoltage_event) begin
               next_s.st = entry_state(p.batt_below_fast);
            end
         end
         ccs_pkg::ST_PRE: begin
            if (~p.batt_below_fast) begin
               next_s.st = ccs_pkg::ST_FAST;
            end
         end
         ccs_pkg::ST_FAST: begin
            if (term_ev) begin
               next_s.st = ccs_pkg::ST_DONE;
            end
         end
         ccs_pkg::ST_DONE: begin
            // Recharge once discharged below the recharge level
            if (~s.topoff_on & ~p.batt_above_rechg) begin
               next_s.st       = entry_state(p.batt_below_fast);
               next_s.safe_cnt = 16'h0000;
            end
         end
         default: begin
            next_s.st = ccs_pkg::ST_IDLE;
         end
      endcase

      // Safety timer, held by the tick generator during faults
      if (charging & tick & cfg_in.safety_timer_enable) begin
         next_s.safe_cnt = s.safe_cnt + 16'h0001;
      end
      if (safe_exp_ev) begin
         next_s.safe_fault = 1'b1;
         next_s.st         = ccs_pkg::ST_IDLE;
      end

      // Top-off segment
      if (s.topoff_on & tick) begin
         next_s.top_cnt = s.top_cnt + 12'h001;
      end
      if (top_exp_ev) begin
         next_s.topoff_on = 1'b0;
      end
      if (term_ev) begin
         // Length captured here only
         next_s.top_cnt   = 12'h000;
         next_s.top_lim   = 12'(cfg_in.topoff_sel * ccs_pkg::TOPOFF_STEP_TICKS);
         next_s.topoff_on = top_start_ev;
      end

      // Restart clears timers and fault; disable stops the cycle
      if (en_rise) begin
         next_s.safe_cnt   = 16'h0000;
         next_s.safe_fault = 1'b0;
         next_s.top_cnt    = 12'h000;
         next_s.topoff_on  = 1'b0;
      end
      if (reg_defaults_in) begin
         next_s.top_cnt   = 12'h000;
         next_s.topoff_on = 1'b0;
      end
      if (~enabled) begin
         next_s.st        = ccs_pkg::ST_IDLE;
         next_s.topoff_on = 1'b0;
      end

      // Boost enable: host write first, hardware clears override it
      if (boost_wr_in) begin
         next_s.boost_en = boost_wdata_in;
         if (boost_wdata_in) begin
            next_s.boost_fault = 1'b0;
            next_s.retry_cnt   = 3'h0;
            next_s.retry_wait  = 12'h000;
         end
      end
      if (s.retry_wait != 12'h000) begin
         next_s.retry_wait = s.retry_wait - 12'h001;
      end
      if (s.boost_run & p.boost_short & ~boost_ov_ev) begin
         if (boost_fail_ev) begin
            next_s.boost_en    = 1'b0;
            next_s.boost_fault = 1'b1;
            next_s.retry_cnt   = 3'h0;
         end else begin
            next_s.retry_cnt  = s.retry_cnt + 3'h1;
            next_s.retry_wait = ccs_pkg::RETRY_CYC;
         end
      end
      if (boost_ov_ev) begin
         next_s.boost_en    = 1'b0;
         next_s.boost_fault = 1'b1;
      end
      // Boost pauses out of its temperature range or while retrying
      next_s.boost_run = next_s.boost_en & p.thermistor_sense_boost_ok
                         & (next_s.retry_wait == 12'h000);
      next_s.therm_fault = s.boost_en & ~p.thermistor_sense_boost_ok;
      if (s.boost_en) begin
         next_s.src_field = p.thermistor_sense_boost_ok ? ccs_pkg::SRC_BOOST
                                                        : ccs_pkg::SRC_NONE;
      end else begin
         next_s.src_field = cfg_in.detected_source;
      end

      // Merged interrupt pulse
      if (any_ev & (s.int_cnt == 12'h000)) begin
         next_s.int_cnt = ccs_pkg::INT_CYC;
      end else if (s.int_cnt != 12'h000) begin
         next_s.int_cnt = s.int_cnt - 12'h001;
      end
      next_s.int_n = (next_s.int_cnt == 12'h000);

      // Status and power-stage controls
      next_s.phase = phase_of(next_s.st);
      if (next_s.safe_fault) begin
         next_s.fault_field = ccs_pkg::FLT_TIMER;
      end else if (p.input_overvoltage_event) begin
         next_s.fault_field = ccs_pkg::FLT_INOV;
      end else begin
         next_s.fault_field = ccs_pkg::FLT_NONE;
      end
      next_s.ov_sel  = cfg_in.input_overvoltage_select;
      next_s.chg_act = ((next_s.st == ccs_pkg::ST_PRE)
                        | (next_s.st == ccs_pkg::ST_FAST) | next_s.topoff_on)
                       & ~hold;
      // Battery switch opens once the cycle is complete
      next_s.batt_sw = enabled & ~((next_s.st == ccs_pkg::ST_DONE)
                                   & ~next_s.topoff_on);
      next_s.sys_dis = p.system_overvoltage_event & p.sys_at_min;
      next_s.sw_en   = ~p.input_overvoltage_event & ~next_s.sys_dis
                       & ~boost_ov_ev;
      next_s.vreg_4v1 = p.thermistor_sense_warm
                        & cfg_in.warm_voltage_select;
      next_s.cut_20   = p.thermistor_sense_cool
                        & cfg_in.cool_current_select;
   end

   always_ff @(posedge clk_in) begin
      if (srst_in) begin
         s       <= '0;
         s.st    <= ccs_pkg::ST_IDLE;
         s.int_n <= 1'b1;
      end else begin
         s <= next_s;
      end
   end

   assign charge_phase_field_out    = s.phase;
   assign charge_fault_field_out    = s.fault_field;
   assign topoff_running_flag_out   = s.topoff_on;
   assign thermistor_fault_flag_out = s.therm_fault;
   assign boost_fault_flag_out      = s.boost_fault;
   assign boost_enable_out          = s.boost_en;
   assign boost_active_out          = s.boost_run;
   assign input_source_field_out    = s.src_field;
   assign ov_threshold_sel_out      = s.ov_sel;
   assign charge_active_out         = s.chg_act;
   assign battery_switch_on_out     = s.batt_sw;
   assign switching_en_out          = s.sw_en;
   assign sys_discharge_out         = s.sys_dis;
   assign vreg_fixed_4v1_out        = s.vreg_4v1;
   assign ichg_cut_20pct_out        = s.cut_20;
   assign int_n_out                 = s.int_n;

   default clocking cb @(posedge clk_in); endclocking
   default disable iff (srst_in);

   term_phase_a: assert property (
      term_ev |=> (charge_phase_field_out == ccs_pkg::PH_DONE) && !int_n_out)
      else $error("termination did not report done with interrupt");
   no_term_a: assert property (
      (s.st == ccs_pkg::ST_FAST) && !cfg_in.term_enable
      |=> s.st != ccs_pkg::ST_DONE)
      else $error("terminated with termination disabled");
   limit_block_a: assert property (
      (s.st == ccs_pkg::ST_FAST) && limiting |=> s.st != ccs_pkg::ST_DONE)
      else $error("terminated while limiting");
   topoff_flag_a: assert property (
      top_start_ev |=> topoff_running_flag_out ##1 topoff_running_flag_out)
      else $error("top-off flag not raised at start");
   start_window_a: assert property (
      (s.st == ccs_pkg::ST_IDLE) && !p.thermistor_sense_ok
      |=> s.st == ccs_pkg::ST_IDLE)
      else $error("charge started outside temperature window");
   safe_expire_a: assert property (
      safe_exp_ev |=> (charge_fault_field_out == ccs_pkg::FLT_TIMER)
      && (charge_phase_field_out == ccs_pkg::PH_DIS))
      else $error("safety expiry not reported");
   input_ov_a: assert property (
      p.input_overvoltage_event && !s.safe_fault && !safe_exp_ev
      |=> !switching_en_out && (charge_fault_field_out == ccs_pkg::FLT_INOV))
      else $error("input overvoltage not handled");
   sys_ov_a: assert property (
      p.system_overvoltage_event && p.sys_at_min
      |=> sys_discharge_out && !switching_en_out)
      else $error("system overvoltage not clamped");
   boost_fail_a: assert property (
      boost_fail_ev && !boost_wr_in
      |=> !boost_enable_out && boost_fault_flag_out && !int_n_out)
      else $error("boost retry exhaustion not handled");
   boost_ov_a: assert property (
      boost_ov_ev |=> !boost_enable_out && boost_fault_flag_out
      && !switching_en_out)
      else $error("boost overvoltage not handled");
   boost_temp_a: assert property (
      s.boost_en && !p.thermistor_sense_boost_ok && !boost_wr_in
      |=> (input_source_field_out == ccs_pkg::SRC_NONE)
      && thermistor_fault_flag_out && !boost_active_out)
      else $error("boost temperature suspension missing");
   int_width_a: assert property (
      $fell(int_n_out) |=> !int_n_out [*8])
      else $error("interrupt pulse too short");

   term_c:       cover property (term_ev);
   topoff_end_c: cover property (top_exp_ev);
   safe_exp_c:   cover property (safe_exp_ev);
   boost_fail_c: cover property (boost_fail_ev);
endmodule
`default_nettype wire

// ===== ccs_pkg.sv
// Shared constants, encodings and carrier types of the charge supervisor
package ccs_pkg;

   localparam int CLK_HZ = 10_000_000;

   // Timer base period and its length in clock cycles
   localparam int TICK_MS  = 1000;
   localparam int TICK_CYC = (CLK_HZ / 1000) * TICK_MS;

   // Safety and top-off durations in their own units
   localparam int SAFE_LOW_H      = 2;
   localparam int SAFE_SHORT_H    = 5;
   localparam int SAFE_LONG_H     = 10;
   localparam int TOPOFF_STEP_MIN = 15;

   // Same durations counted in timer ticks
   localparam logic [15:0] SAFE_LOW_TICKS =
      16'(SAFE_LOW_H * 3600 * 1000 / TICK_MS);
   localparam logic [15:0] SAFE_SHORT_TICKS =
      16'(SAFE_SHORT_H * 3600 * 1000 / TICK_MS);
   localparam logic [15:0] SAFE_LONG_TICKS =
      16'(SAFE_LONG_H * 3600 * 1000 / TICK_MS);
   localparam logic [11:0] TOPOFF_STEP_TICKS =
      12'(TOPOFF_STEP_MIN * 60 * 1000 / TICK_MS);

   // Interrupt pulse width and boost retry pause
   localparam int INT_US   = 256;
   localparam int RETRY_US = 400;
   localparam logic [11:0] INT_CYC   = 12'(INT_US * (CLK_HZ / 1_000_000));
   localparam logic [11:0] RETRY_CYC = 12'(RETRY_US * (CLK_HZ / 1_000_000));
   localparam logic [2:0]  BOOST_RETRIES = 3'h7;

   // Charge phase codes
   localparam logic [1:0] PH_DIS  = 2'h0;
   localparam logic [1:0] PH_PRE  = 2'h1;
   localparam logic [1:0] PH_FAST = 2'h2;
   localparam logic [1:0] PH_DONE = 2'h3;

   // Charge fault codes
   localparam logic [1:0] FLT_NONE  = 2'h0;
   localparam logic [1:0] FLT_INOV  = 2'h1;
   localparam logic [1:0] FLT_TIMER = 2'h3;

   // Input source codes forced in boost mode
   localparam logic [2:0] SRC_NONE  = 3'h0;
   localparam logic [2:0] SRC_BOOST = 3'h7;

   typedef enum logic [3:0] {
      ST_IDLE = 4'b0001,
      ST_PRE  = 4'b0010,
      ST_FAST = 4'b0100,
      ST_DONE = 4'b1000
   } ccs_state_e;

   // Comparator and pin levels from the analog side
   typedef struct packed {
      logic batt_above_rechg;
      logic batt_low;
      logic batt_below_fast;
      logic cur_below_term;
      logic input_current_limit_flag;
      logic input_voltage_limit;
      logic thermal_reg;
      logic thermistor_sense_ok;
      logic thermistor_sense_cool;
      logic thermistor_sense_warm;
      logic thermistor_sense_boost_ok;
      logic input_overvoltage_event;
      logic system_overvoltage_event;
      logic sys_at_min;
      logic boost_short;
      logic boost_overvoltage;
      logic charge_enable_pin_n;
   } ccs_pins_s;

   // Host configuration bits
   typedef struct packed {
      logic       charge_enable_bit;
      logic       term_enable;
      logic [1:0] topoff_sel;
      logic       warm_voltage_select;
      logic       cool_current_select;
      logic       safety_duration_field;
      logic       safety_timer_enable;
      logic       slow_count_enable;
      logic [2:0] input_overvoltage_select;
      logic [2:0] detected_source;
   } ccs_cfg_s;

endpackage

// ===== ccs_tick_gen.sv
// Timer prescaler with hold and half-rate tick
`timescale 1ns/1ns
`default_nettype none
module ccs_tick_gen #(
   parameter int TICK_CYC = ccs_pkg::TICK_CYC
) (
   input  wire logic clk_in,
   input  wire logic srst_in,
   input  wire logic run_in,
   input  wire logic slow_in,
   output var  logic tick_out
);
   localparam int W = $clog2(TICK_CYC);

   typedef struct packed {
      logic [W-1:0] cnt;
      logic         half;
      logic         tick;
   } ccs_tick_s;

   ccs_tick_s s;
   ccs_tick_s next_s;

   always_comb begin
      next_s      = s;
      next_s.tick = 1'b0;
      if (run_in) begin
         if (s.cnt == W'(TICK_CYC - 1)) begin
            next_s.cnt  = '0;
            next_s.half = ~s.half;
            // Slowed: only every other period yields a tick
            next_s.tick = ~slow_in | s.half;
         end else begin
            next_s.cnt = s.cnt + W'(1);
         end
      end
   end

   always_ff @(posedge clk_in) begin
      if (srst_in) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   assign tick_out = s.tick;
endmodule
`default_nettype wire

// ===== ccs_host_model.sv
// Host-side model counting interrupt pulses and their width
`timescale 1ns/1ns
`default_nettype none
module ccs_host_model (
   input  wire logic        clk_in,
   input  wire logic        int_n_in,
   output var  logic [7:0]  pulses_out,
   output var  logic [15:0] width_out
);
   logic [15:0] run;
   initial begin
      pulses_out = 8'h00;
      width_out  = 16'h0000;
      run        = 16'h0000;
   end
   always @(posedge clk_in) begin
      if (int_n_in === 1'b0) begin
         run <= run + 16'h0001;
      end else if (run != 16'h0000) begin
         pulses_out <= pulses_out + 8'h01;
         width_out  <= run;
         run        <= 16'h0000;
      end
   end
endmodule
`default_nettype wire

// ===== ccs_supervisor_test.sv
// Testbench of the charge cycle supervisor
`timescale 1ns/1ns
`default_nettype none
module ccs_supervisor_test;
   localparam int TICK = 4;
   logic               clk_in, srst_in, wr, wd, v0, rd;
   ccs_pkg::ccs_pins_s p;
   ccs_pkg::ccs_cfg_s  c;
   logic [1:0]         ph, flt;
   logic [2:0]         src, ovs;
   logic               top, tflt, bflt, ben, bact, act, bsw, swe, dis;
   logic               v41, cut, int_n;
   logic [7:0]         np, p0;
   logic [15:0]        wid;
   int                 num_errors, checks_done, cyc;
   ccs_supervisor #(.TICK_CYC(TICK)) DUT (
      .clk_in(clk_in), .srst_in(srst_in), .pins_in(p), .cfg_in(c),
      .reg_defaults_in(rd), .boost_wr_in(wr), .boost_wdata_in(wd),
      .charge_phase_field_out(ph), .charge_fault_field_out(flt),
      .topoff_running_flag_out(top), .thermistor_fault_flag_out(tflt),
      .boost_fault_flag_out(bflt), .boost_enable_out(ben),
      .boost_active_out(bact), .input_source_field_out(src),
      .ov_threshold_sel_out(ovs), .charge_active_out(act),
      .battery_switch_on_out(bsw), .switching_en_out(swe),
      .sys_discharge_out(dis), .vreg_fixed_4v1_out(v41),
      .ichg_cut_20pct_out(cut), .int_n_out(int_n)
   );
   ccs_host_model host (
      .clk_in(clk_in), .int_n_in(int_n), .pulses_out(np), .width_out(wid)
   );
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      checks_done++;
      if (seen !== exp) begin
         num_errors++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic step(input int n);
      repeat (n) @(negedge clk_in);
   endtask
   task automatic end_sim();
      $display("errors %0d checks %0d", num_errors, checks_done);
      if (num_errors == 0 && checks_done > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   task automatic t_charge();
      c.charge_enable_bit = 1'b1;
      p.thermistor_sense_ok = 1'b1;
      p.batt_below_fast = 1'b1;
      step(6);
      check(ph, ccs_pkg::PH_PRE);
      p.thermistor_sense_ok = 1'b0;
      step(5);
      check(act, 1'b0);
      p.thermistor_sense_ok = 1'b1;
      p.batt_below_fast = 1'b0;
      step(5);
      check(ph, ccs_pkg::PH_FAST);
      p.thermistor_sense_warm = 1'b1;
      step(5);
      v0 = v41;
      c.warm_voltage_select = 1'b1;
      step(3);
      check({v0, v41}, 2'h1);
      p.thermistor_sense_warm = 1'b0;
      p.thermistor_sense_cool = 1'b1;
      step(5);
      v0 = cut;
      c.cool_current_select = 1'b1;
      step(3);
      check({v0, cut}, 2'h1);
      p.thermistor_sense_cool = 1'b0;
   endtask
   task automatic t_term();
      p.batt_above_rechg = 1'b1;
      p.cur_below_term = 1'b1;
      step(6);
      check(ph, ccs_pkg::PH_FAST);
      // Limit flag must be through the synchroniser before enabling
      p.input_current_limit_flag = 1'b1;
      step(3);
      c.term_enable = 1'b1;
      step(6);
      check(ph, ccs_pkg::PH_FAST);
      p0 = np;
      p.input_current_limit_flag = 1'b0;
      step(6);
      check(ph, ccs_pkg::PH_DONE);
      check(int_n, 1'b0);
      check({top, bsw}, 2'h3);
      c.topoff_sel = 2'h3;
      step(2600);
      check(np, p0 + 8'h01);
      check(wid, 16'(ccs_pkg::INT_CYC));
      step(900 * TICK - 2700);
      check(top, 1'b1);
      step(200);
      check({top, bsw, int_n}, 3'h0);
      step(2600);
      check(np, p0 + 8'h02);
      p.batt_above_rechg = 1'b0;
      step(5);
      check(ph, ccs_pkg::PH_FAST);
      p.batt_above_rechg = 1'b1;
      step(5);
      check({ph, top}, 3'h7);
      rd = 1'b1;
      step(1);
      rd = 1'b0;
      step(1);
      check({ph, top}, 3'h6);
   endtask
   task automatic t_faults();
      c.input_overvoltage_select = 3'h5;
      p.input_overvoltage_event = 1'b1;
      step(5);
      check({flt, swe, ovs}, {ccs_pkg::FLT_INOV, 1'b0, 3'h5});
      p.input_overvoltage_event = 1'b0;
      step(5);
      check({flt, swe}, {ccs_pkg::FLT_NONE, 1'b1});
      p.sys_at_min = 1'b1;
      p.system_overvoltage_event = 1'b1;
      step(5);
      check({dis, swe}, 2'h2);
      p.system_overvoltage_event = 1'b0;
      p.sys_at_min = 1'b0;
   endtask
   task automatic t_safety();
      c.charge_enable_bit = 1'b0;
      p.batt_above_rechg = 1'b0;
      p.cur_below_term = 1'b0;
      p.batt_low = 1'b1;
      step(3);
      c.charge_enable_bit = 1'b1;
      c.slow_count_enable = 1'b1;
      p.thermistor_sense_cool = 1'b1;
      step(5);
      check(ph, ccs_pkg::PH_FAST);
      step(795);
      // Cool band at half rate for 800 cycles delays expiry by 400
      p.thermistor_sense_cool = 1'b0;
      step(7200 * TICK - 495);
      check(flt, ccs_pkg::FLT_NONE);
      step(200);
      check({flt, ph}, {ccs_pkg::FLT_TIMER, ccs_pkg::PH_DIS});
   endtask
   task automatic t_boost();
      p.thermistor_sense_boost_ok = 1'b1;
      wr = 1'b1;
      wd = 1'b1;
      step(1);
      wr = 1'b0;
      step(4);
      check({ben, bact, src}, {2'h3, ccs_pkg::SRC_BOOST});
      p.thermistor_sense_boost_ok = 1'b0;
      step(5);
      check({bact, tflt, src}, {2'h1, ccs_pkg::SRC_NONE});
      p.thermistor_sense_boost_ok = 1'b1;
      step(5);
      check({bact, tflt}, 2'h2);
      p.boost_overvoltage = 1'b1;
      step(5);
      check({ben, bact, bflt}, 3'h1);
      p.boost_overvoltage = 1'b0;
      p.boost_short = 1'b1;
      step(3);
      wr = 1'b1;
      wd = 1'b1;
      step(1);
      wr = 1'b0;
      step(2);
      check({ben, bflt}, 2'h2);
      // Seven retries, each a pause plus one running cycle
      step(7 * (int'(ccs_pkg::RETRY_CYC) + 1) - 10);
      check({ben, bflt}, 2'h2);
      step(20);
      check({ben, bflt, int_n}, 3'h2);
   endtask
   initial begin
      clk_in = 1'b0;
      forever #50 clk_in = ~clk_in;
   end
   always @(posedge clk_in) begin
      cyc++;
      if (cyc == 80000) begin
         num_errors++;
         end_sim();
      end
   end
   initial begin
      p = '0;
      c = '0;
      c.safety_timer_enable = 1'b1;
      c.topoff_sel = 2'h1;
      wr = 1'b0;
      wd = 1'b0;
      rd = 1'b0;
      srst_in = 1'b1;
      step(2);
      srst_in = 1'b0;
      step(1);
      check({ph, flt, int_n}, 5'h01);
      t_charge();
      t_term();
      t_faults();
      t_safety();
      t_boost();
      end_sim();
   end
endmodule
`default_nettype wire
